// file: hw/mdt_pkg.sv
// Purpose: shared constants and types of the multimode delay timer core
// Assumes: 100 MHz clock
// Notes:   times in ms, cycle counts derived from the clock rate
package mdt_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned MIN_PULSE_MS  = 50;
  localparam int unsigned DEB_CYC       =
    (CLK_HZ / 1000) * MIN_PULSE_MS / 2;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYC      = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned PRESET_W      = 24;
  localparam int unsigned ELAPSED_W     = 26;

  // full scale per range in ticks (ms): 1.2, 3, 12, 30 s
  localparam logic [ELAPSED_W-1:0] FS_R0 = 26'h00004B0;
  localparam logic [ELAPSED_W-1:0] FS_R1 = 26'h0000BB8;
  localparam logic [ELAPSED_W-1:0] FS_R2 = 26'h0002EE0;
  localparam logic [ELAPSED_W-1:0] FS_R3 = 26'h0007530;
  localparam logic [9:0]           DIAL_FULL = 10'h3FF;

  // apb register map
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_DIAL    = 12'h004;
  localparam logic [11:0] ADDR_STATUS  = 12'h008;
  localparam logic [11:0] ADDR_ELAPSED = 12'h00C;
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_RANGE_LSB = 4;
  localparam int unsigned CTRL_DOUBLE    = 6;
  localparam int unsigned CTRL_NOINPUT   = 7;
  localparam int unsigned CTRL_STARTONLY = 8;
  localparam int unsigned CTRL_NOONLY    = 9;
  localparam int unsigned DIAL_ZERO_BIT  = 10;

  typedef enum logic [2:0] {
    MDT_ON_DELAY, MDT_FLICK_OFF, MDT_FLICK_ON, MDT_SIG_ONOFF,
    MDT_SIG_OFF, MDT_INTERVAL, MDT_ONE_SHOT, MDT_SIG_ONOFF2
  } mdt_mode_e;

  typedef struct packed {
    logic start;
    logic reset;
    logic gate;
  } mdt_in_s;

  typedef struct packed {
    logic out_no;
    logic out_nc;
  } mdt_out_s;
endpackage

// file: hw/mdt_debounce.sv
// Purpose: synchroniser and debounce filter for one contact input
// Assumes: inputs may bounce; stable level must hold DEB_CYC cycles
// Notes:   first flop feeds only the second
`timescale 1ns/1ps
module mdt_debounce
#(
  parameter int unsigned CYC = 16
)
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // raw and filtered level
  input  wire logic raw,
  output logic      clean
);
  logic       s1_r;
  logic       s2_r;
  logic [$clog2(CYC+1)-1:0] cnt_r;

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
    end

  // level must stay stable for the window before it is believed
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      cnt_r <= '0;
      clean <= 1'b0;
    end
    else if (s2_r == clean)
      cnt_r <= '0;
    else if (cnt_r == ($clog2(CYC+1))'(CYC - 1))
    begin
      cnt_r <= '0;
      clean <= s2_r;
    end
    else
      cnt_r <= cnt_r + 1'b1;
endmodule

// file: hw/mdt_core.sv
// Purpose: multimode delay timer core with apb control registers
// Assumes: inputs synchronous-ish contacts, 100 MHz clock
// Notes:   time base is a 1 ms tick; preset = dial share of full scale
//
// How it works
// [RL1] reset input stops timing, clears count, output off
// [RL2] gate freezes the count, resumes afterwards
// [RL3] output switches per mode at preset
// [RL4] source holds start/reset at least 0.05 s
// [RL5] power stays off 0.1 s when resetting
// [RL6] one-shot gives single pulse per start
// [RL7] dial below zero means instant output
// [RL8] gated portions add up to preset
// [RL9] start and reset work during gate
// [RL10] four full-scale ranges 1.2/3/12/30 s
// [RL11] double scale variant doubles every time
// [RL12] no-input variant starts on power-up
// [RL13] start-only variant resets by power
// [RL14] transistor variant has no NC output
// [RL15] on-delay turns on after preset
// [RL16] off-delay holds output after start drops
// [RL17] flicker modes toggle at preset
// [RL18] inputs synchronised and debounced first
// [RL19] power-up gives zero count, output off
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
module mdt_core
  import mdt_pkg::*;
#(
  parameter int unsigned DEB_CYCLES  = mdt_pkg::DEB_CYC,
  parameter int unsigned TICK_CYCLES = mdt_pkg::TICK_CYC
)
(
  // clock and reset
  input  wire logic             clock,
  input  wire logic             arst_n,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // contact inputs
  input  wire mdt_pkg::mdt_in_s pins,
  // control output
  output mdt_pkg::mdt_out_s     ctl_out
);
  import mdt_pkg::*;

  logic rs1_r, rst_n;
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end

  // registers
  logic [9:0]  ctrl_r;
  logic [10:0] dial_r;
  mdt_mode_e   mode;
  assign mode = mdt_mode_e'(ctrl_r[CTRL_MODE_LSB +: 3]);

  // debounced inputs
  logic st_c, rs_c, gt_c;
  mdt_debounce #(.CYC(DEB_CYCLES)) u_st
    (.clock(clock), .rst_n(rst_n), .raw(pins.start), .clean(st_c)); // see [RL18]
  mdt_debounce #(.CYC(DEB_CYCLES)) u_rs
    (.clock(clock), .rst_n(rst_n), .raw(pins.reset), .clean(rs_c)); // see [RL18]
  mdt_debounce #(.CYC(DEB_CYCLES)) u_gt
    (.clock(clock), .rst_n(rst_n), .raw(pins.gate), .clean(gt_c)); // see [RL18]

  // start-only variant ignores reset and gate pins
  logic st_i, rs_i, gt_i;
  assign st_i = ctrl_r[CTRL_NOINPUT] ? 1'b1 : st_c; // see [RL12]
  assign rs_i = ctrl_r[CTRL_NOINPUT] | ctrl_r[CTRL_STARTONLY]
                ? 1'b0 : rs_c; // see [RL13]
  assign gt_i = ctrl_r[CTRL_NOINPUT] | ctrl_r[CTRL_STARTONLY]
                ? 1'b0 : gt_c;

  logic st_d_r;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      st_d_r <= 1'b0;
    else
      st_d_r <= st_i;
  logic st_rise, st_fall;
  assign st_rise = st_i & ~st_d_r;
  assign st_fall = ~st_i & st_d_r;

  // preset from range and dial share
  logic [ELAPSED_W-1:0] fs;
  always_comb
  begin
    unique case (ctrl_r[CTRL_RANGE_LSB +: 2])
      2'h0: fs = FS_R0;
      2'h1: fs = FS_R1;
      2'h2: fs = FS_R2;
      default: fs = FS_R3;
    endcase // see [RL10]
    if (ctrl_r[CTRL_DOUBLE])
      fs = {fs[ELAPSED_W-2:0], 1'b0}; // see [RL11]
  end
  logic [ELAPSED_W+9:0] prod;
  logic [ELAPSED_W-1:0] preset;
  assign prod   = fs * dial_r[9:0];
  assign preset = dial_r[DIAL_ZERO_BIT] ? '0 // see [RL7]
                  : prod[ELAPSED_W+9:10];

  // time base
  logic [$clog2(TICK_CYCLES+1)-1:0] pre_r;
  logic tick;
  assign tick = pre_r == ($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1);

  logic [ELAPSED_W-1:0] el_r;
  logic run_r, out_r, done_r, flk_r;
  logic reached;
  assign reached = el_r >= preset;

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      pre_r <= '0;
    else if (tick | ~run_r | gt_i)
      pre_r <= '0;
    else
      pre_r <= pre_r + 1'b1;

  // timing engine: run marks the measured interval
  logic start_ev, arm_ev;
  assign start_ev = (mode == MDT_SIG_OFF || mode == MDT_SIG_ONOFF
                     || mode == MDT_SIG_ONOFF2) ? st_fall : st_rise;
  assign arm_ev = st_rise;

  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      el_r   <= '0; // see [RL19]
      run_r  <= 1'b0;
      out_r  <= 1'b0;
      done_r <= 1'b0;
      flk_r  <= 1'b0;
    end
    else if (rs_i)
    begin
      el_r   <= '0; // see [RL1]
      run_r  <= 1'b0;
      out_r  <= 1'b0;
      done_r <= 1'b0;
      flk_r  <= 1'b0;
    end
    else
    begin
      unique case (mode)
        MDT_ON_DELAY, MDT_INTERVAL, MDT_ONE_SHOT:
        begin
          if (arm_ev && !(mode == MDT_ONE_SHOT && done_r)) // see [RL9]
          begin
            el_r  <= '0;
            run_r <= 1'b1;
            out_r <= mode != MDT_ON_DELAY;
          end
          else if (run_r && reached)
          begin
            run_r  <= 1'b0;
            done_r <= 1'b1; // see [RL6]
            out_r  <= mode == MDT_ON_DELAY; // see [RL15] [RL3]
          end
          else if (run_r && tick && !gt_i)
            el_r <= el_r + 1'b1; // see [RL2] [RL8]
          if (mode != MDT_ON_DELAY && !st_i && !run_r)
            done_r <= 1'b0;
        end
        MDT_FLICK_OFF, MDT_FLICK_ON:
        begin
          if (arm_ev)
          begin
            el_r  <= '0;
            run_r <= 1'b1;
            out_r <= mode == MDT_FLICK_ON;
          end
          else if (run_r && reached)
          begin
            el_r  <= '0;
            out_r <= ~out_r; // see [RL17]
          end
          else if (run_r && tick && !gt_i)
            el_r <= el_r + 1'b1; // see [RL2]
        end
        default:
        begin
          if (arm_ev)
          begin
            run_r <= 1'b0;
            el_r  <= '0;
            out_r <= 1'b1;
            flk_r <= 1'b0;
          end
          else if (start_ev && out_r)
          begin
            run_r <= 1'b1;
            el_r  <= '0;
          end
          else if (run_r && reached)
          begin
            run_r <= 1'b0;
            out_r <= 1'b0; // see [RL16]
          end
          else if (run_r && tick && !gt_i)
            el_r <= el_r + 1'b1; // see [RL2]
        end
      endcase
    end

  // outputs
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      ctl_out <= '0;
    else
    begin
      ctl_out.out_no <= out_r;
      ctl_out.out_nc <= ~out_r & ~ctrl_r[CTRL_NOONLY] & ~rs_i; // see [RL14]
    end

  // apb slave, zero wait states
  logic wr, rd;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      ctrl_r <= '0;
      dial_r <= '0;
    end
    else if (wr)
    begin
      if (paddr == ADDR_CTRL)
        ctrl_r <= pwdata[9:0];
      if (paddr == ADDR_DIAL)
        dial_r <= pwdata[10:0];
    end

  logic mapped;
  assign mapped = paddr == ADDR_CTRL || paddr == ADDR_DIAL
                  || paddr == ADDR_STATUS || paddr == ADDR_ELAPSED;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= '0;
      if (rd && !penable)
        unique case (paddr)
          ADDR_CTRL:   prdata <= {22'h000000, ctrl_r};
          ADDR_DIAL:   prdata <= {21'h000000, dial_r};
          ADDR_STATUS: prdata <= {26'h0000000, gt_i, rs_i, st_i,
                                  done_r, run_r, out_r};
          ADDR_ELAPSED: prdata <= {6'h00, el_r};
          default:     prdata <= '0;
        endcase
    end

  // checks
  a_reset_clears: assert property (@(posedge clock) disable iff (!rst_n)
    rs_i |=> (el_r == '0 && !out_r && !run_r)) // see [RL1]
    else $error("reset did not clear timer");
  a_gate_freeze: assert property (@(posedge clock) disable iff (!rst_n)
    (gt_i && !rs_i && !arm_ev && !(run_r && reached)) |=> $stable(el_r)) // see [RL2]
    else $error("count moved while gated");
  a_ondelay_out: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == MDT_ON_DELAY && run_r && reached && !rs_i && !arm_ev)
    |=> out_r ##1 ctl_out.out_no) // see [RL15]
    else $error("on-delay output missing");
  a_oneshot_once: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == MDT_ONE_SHOT && done_r && st_i && !rs_i) |=> !run_r) // see [RL6]
    else $error("one-shot restarted");
  a_zero_inst: assert property (@(posedge clock) disable iff (!rst_n)
    (dial_r[DIAL_ZERO_BIT] && mode == MDT_ON_DELAY && run_r && !rs_i
     && !arm_ev) |=> out_r) // see [RL7]
    else $error("zero dial not instant");
  a_nc_absent: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl_r[CTRL_NOONLY] |=> !ctl_out.out_nc) // see [RL14]
    else $error("nc output on transistor variant");
  a_flick_toggle: assert property (@(posedge clock) disable iff (!rst_n)
    ((mode == MDT_FLICK_OFF || mode == MDT_FLICK_ON) && run_r && reached
     && !rs_i && !arm_ev) |=> out_r != $past(out_r)) // see [RL17]
    else $error("flicker did not toggle");
  a_offdly_rel: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == MDT_SIG_OFF && run_r && reached && !rs_i && !arm_ev
     && !start_ev) |=> !out_r) // see [RL16]
    else $error("off-delay not released");
  a_apb_ready: assert property (@(posedge clock) disable iff (!rst_n)
    (psel && !penable) |=> pready)
    else $error("apb ready late");
  c_oneshot: cover property (@(posedge clock) disable iff (!rst_n)
    mode == MDT_ONE_SHOT && done_r);
  c_gate_run: cover property (@(posedge clock) disable iff (!rst_n)
    run_r && gt_i);
  c_flicker: cover property (@(posedge clock) disable iff (!rst_n)
    mode == MDT_FLICK_ON && run_r && reached);
endmodule

// file: dv/mdt_contacts.sv
// Purpose: contact inputs with chatter, and a watcher on the load
// Assumes: bench sets wanted levels {start,reset,gate} after an edge
// Notes:   only the contacts that change chatter, for three cycles
`timescale 1ns/1ps
module mdt_contacts
  import mdt_pkg::*;
(
  // clock
  input  wire logic              clock,
  // wanted contact levels
  input  wire logic [2:0]        want,
  // pins and load
  output mdt_pkg::mdt_in_s       pins,
  input  wire mdt_pkg::mdt_out_s ctl_out,
  output int                     rises
);
  logic [2:0] last_r;
  logic [2:0] diff_r;
  logic [1:0] chat_r;
  logic       load_r;

  initial
  begin
    pins   = '0;
    rises  = 0;
    last_r = 3'h0;
    diff_r = 3'h0;
    chat_r = 2'h0;
    load_r = 1'b0;
  end

  // a real contact bounces, so the filter has to ride it out
  always @(posedge clock)
  begin
    last_r <= want;
    if (want != last_r)
    begin
      diff_r <= want ^ last_r;
      chat_r <= 2'h3;
    end
    else if (chat_r != 2'h0)
      chat_r <= chat_r - 2'h1;
    pins <= (chat_r != 2'h0) ? (pins ^ diff_r) : want;
  end

  // count load switch-ons
  always @(posedge clock)
  begin
    load_r <= ctl_out.out_no;
    if (ctl_out.out_no && !load_r)
      rises <= rises + 1;
  end
endmodule

// file: dv/testbench.sv
// Purpose: self-checking bench of the delay timer core
// Assumes: short debounce and tick counts to keep the run short
// Notes:   expected times come from full scale and dial share
`timescale 1ns/1ps
module testbench;
  import mdt_pkg::*;
  localparam int TCK = 2;
  logic        clock   = 1'b0;
  logic        arst_n  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [2:0]  want    = 3'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] q;
  mdt_in_s     pins;
  mdt_out_s    ctl_out;
  int          rises;
  int          t;
  int          miscompares = 0;
  int          cmp_count   = 0;

  always #5 clock = ~clock;

  mdt_core #(.DEB_CYCLES(4), .TICK_CYCLES(TCK)) dut
  (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .ctl_out(ctl_out)
  );

  mdt_contacts contacts
  (
    .clock(clock), .want(want), .pins(pins), .ctl_out(ctl_out),
    .rises(rises)
  );

  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic win(string n, int v, int lo, int hi);
    chk(n, v >= lo && v <= hi, 32'h1);
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    chk("pready", pready, 32'h1);
    chk("pslverr", pslverr, a > 12'h00C);
    if (n >= 20)
      end_sim();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdc(string n, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask

  // levels are held h cycles, well past the minimum pulse except the blip in t_idle
  task automatic hold(logic [2:0] w, int h);
    want <= w;
    cyc(h);
  endtask

  task automatic rst_in;
    hold(3'h2, 16);
    hold(3'h0, 16);
  endtask

  task automatic wait_out(logic l, int b);
    t = 0;
    while (ctl_out.out_no !== l && t < b)
    begin
      @(posedge clock);
      t++;
    end
    chk("out_no", ctl_out.out_no, l);
    if (t >= b)
      end_sim();
  endtask

  task automatic t_idle;
    rdc("status", ADDR_STATUS, 32'h0);
    rdc("elapsed", ADDR_ELAPSED, 32'h0);
    chk("out_nc", ctl_out.out_nc, 32'h1);
    rdc("unmapped", 12'h010, 32'h0);
    // a chattering blip shorter than the filter must not start
    hold(3'h4, 2);
    hold(3'h0, 30);
    rdc("blip", ADDR_STATUS, 32'h0);
  endtask

  task automatic t_range;
    int fs;
    int c;
    for (int d = 0; d < 2; d++)
      for (int r = 0; r < 4; r++)
      begin
        fs = r == 0 ? FS_R0 : r == 1 ? FS_R1 : r == 2 ? FS_R2 : FS_R3;
        c = fs * (d + 1) * 16 / 1024 * TCK;
        apb(1'b1, ADDR_CTRL, (d << CTRL_DOUBLE) | (r << CTRL_RANGE_LSB));
        rst_in();
        hold(3'h4, 0);
        wait_out(1'b1, c + 40);
        win("range time", t, c - 4, c + 24);
        hold(3'h0, 16);
      end
  endtask

  task automatic t_gate;
    logic [31:0] e1;
    apb(1'b1, ADDR_CTRL, 32'h0);
    rst_in();
    hold(3'h4, 24);
    hold(3'h5, 16);
    apb(1'b0, ADDR_ELAPSED, 32'h0);
    e1 = q;
    cyc(60);
    rdc("frozen", ADDR_ELAPSED, e1);
    chk("gated out", ctl_out.out_no, 32'h0);
    hold(3'h4, 0);
    wait_out(1'b1, 80);
    win("resume", t, (18 - e1) * TCK - 4, (18 - e1) * TCK + 24);
    // reset raised while the gate already stands
    hold(3'h5, 16);
    hold(3'h7, 16);
    chk("gated reset", ctl_out.out_no, 32'h0);
    rdc("cleared", ADDR_ELAPSED, 32'h0);
    // start raised while the gate already stands
    hold(3'h1, 16);
    hold(3'h5, 16);
    rdc("gated start", ADDR_STATUS, 32'h2A);
    rst_in();
    apb(1'b1, ADDR_DIAL, 32'h400);
    hold(3'h4, 0);
    wait_out(1'b1, 30);
    hold(3'h0, 16);
    apb(1'b1, ADDR_DIAL, 32'h10);
  endtask

  task automatic t_modes;
    int r0;
    int m;
    // interval and one-shot: one pulse per start, start held long
    for (int k = 5; k < 7; k++)
    begin
      apb(1'b1, ADDR_CTRL, k);
      rst_in();
      r0 = rises;
      hold(3'h4, 0);
      wait_out(1'b1, 30);
      wait_out(1'b0, 60);
      win("shot len", t, 32, 60);
      cyc(120);
      chk("one pulse", rises - r0, 32'h1);
    end
    // every signal-driven off-delay mode
    for (int k = 0; k < 3; k++)
    begin
      m = k == 0 ? 3 : k == 1 ? 4 : 7;
      apb(1'b1, ADDR_CTRL, m);
      rst_in();
      hold(3'h4, 0);
      wait_out(1'b1, 30);
      hold(3'h4, 60);
      chk("held on", ctl_out.out_no, 32'h1);
      hold(3'h0, 0);
      wait_out(1'b0, 80);
      win("off delay", t, 32, 60);
    end
    for (int k = 1; k < 3; k++)
    begin
      apb(1'b1, ADDR_CTRL, k);
      rst_in();
      r0 = rises;
      hold(3'h4, 16);
      hold(3'h0, 384);
      win("flicker", rises - r0, 4, 7);
    end
    rst_in();
  endtask

  task automatic t_variant;
    apb(1'b1, ADDR_CTRL, 32'h200);
    rdc("ctrl", ADDR_CTRL, 32'h200);
    rst_in();
    chk("no nc", ctl_out.out_nc, 32'h0);
    hold(3'h4, 0);
    wait_out(1'b1, 60);
    apb(1'b1, ADDR_CTRL, 32'h100);
    hold(3'h2, 16);
    chk("reset ignored", ctl_out.out_no, 32'h1);
    hold(3'h0, 0);
    // supply removed for a while
    arst_n <= 1'b0;
    cyc(5);
    arst_n <= 1'b1;
    cyc(3);
    chk("power reset", ctl_out.out_no, 32'h0);
    rdc("dial cleared", ADDR_DIAL, 32'h0);
    // dial first, so the power-on shot has a real length
    apb(1'b1, ADDR_DIAL, 32'h10);
    apb(1'b1, ADDR_CTRL, 32'h86);
    wait_out(1'b1, 60);
    wait_out(1'b0, 80);
    win("power shot", t, 32, 60);
    cyc(120);
    chk("power one", ctl_out.out_no, 32'h0);
  endtask

  initial
  begin
    cyc(5);
    // supply held off before power-up
    arst_n <= 1'b1;
    cyc(3);
    t_idle();
    apb(1'b1, ADDR_DIAL, 32'h10);
    rdc("dial", ADDR_DIAL, 32'h10);
    t_range();
    t_gate();
    t_modes();
    t_variant();
    end_sim();
  end
endmodule
